/* logical_and_instruction_unit.sv */
// Execution unit for the AND instruction group, with register slave.
// Assumes a data memory that returns read data one clock after mem_rd.
`timescale 1ns/10ps
module logical_and_instruction_unit (
  input  wire logic        clk,
  input  wire logic        arst_n,
  input  wire logic [5:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  output logic [23:0]      mem_addr,
  output logic             mem_rd,
  output logic             mem_wr,
  output logic [7:0]       mem_wdata,
  input  wire logic [7:0]  mem_rdata,
  output logic             busy
);

  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_RUN  = 1'b1
  } seq_state_t;

  typedef struct packed {
    seq_state_t              st;
    and_unit_pkg::variant_t  var_sel;
    and_unit_pkg::variant_t  act;
    logic                    ir_sel;
    logic                    r_sel;
    logic                    paged;
    logic [31:0]             instr;
    logic [7:0]              acc;
    logic [7:0]              breg;
    logic [7:0]              lreg;
    logic [7:0]              hreg;
    logic [15:0]             ix;
    logic [15:0]             iy;
    logic [7:0]              br;
    logic [7:0]              ep;
    logic [7:0]              xp;
    logic [7:0]              yp;
    logic [7:0]              sc;
    logic [4:0]              cnt;
    logic [4:0]              total;
    logic [7:0]              mem_data;
    logic [23:0]             mem_addr;
    logic                    mem_rd;
    logic                    mem_wr;
    logic [7:0]              mem_wdata;
    logic                    rd_ack;
    logic [31:0]             rdata;
  } core_state_t;

  core_state_t             s;
  core_state_t             next_s;
  datapath_if              dp ();
  logic                    prefixed;
  logic [7:0]              imm;
  logic [31:0]             rd_word;
  logic [31:0]             merged;
  logic                    wr_ok;
  logic                    start;
  and_unit_pkg::variant_t  new_var;
  and_unit_pkg::variant_t  start_var;

  and_logic_unit u_alu (
    .dp (dp.alu)
  );

  address_unit u_agu (
    .dp (dp.agu)
  );

  // Legal variant codes stop at the memory-destination form
  function automatic logic legal(input logic [3:0] code);
    return code <= and_unit_pkg::V_MABS8IMM;
  endfunction

  function automatic logic reads_mem(input and_unit_pkg::variant_t v);
    return and_unit_pkg::mode_of(v) != and_unit_pkg::AM_NONE;
  endfunction

  // Prefixed encoding overrides the software variant select
  assign prefixed = (s.instr[7:0] == and_unit_pkg::PREFIX_BYTE) &&
                    (s.instr[15:8] == and_unit_pkg::PREFIX_AND_H);
  assign imm      = prefixed ? s.instr[23:16] : s.instr[15:8];

  assign dp.mode   = and_unit_pkg::mode_of(s.act);
  assign dp.paged  = s.paged;
  assign dp.ir_sel = s.ir_sel;
  assign dp.br     = s.br;
  assign dp.ep     = s.ep;
  assign dp.xp     = s.xp;
  assign dp.yp     = s.yp;
  assign dp.ll     = s.instr[15:8];
  assign dp.hh     = s.instr[23:16];
  assign dp.l_off  = s.lreg;
  assign dp.hl     = {s.hreg, s.lreg};
  assign dp.ix     = s.ix;
  assign dp.iy     = s.iy;

  // Operand selection per variant
  // Memory forms except V_MABS8IMM fall to the default arm:
  // the accumulator meets the captured byte.

  always_comb begin
    dp.op_a = s.acc;
    dp.op_b = s.mem_data;
    unique case (s.act)
      and_unit_pkg::V_AR: begin
        dp.op_a = s.acc;
        dp.op_b = s.r_sel ? s.breg : s.acc;
      end
      and_unit_pkg::V_AIMM: begin
        dp.op_a = s.acc;
        dp.op_b = imm;
      end
      and_unit_pkg::V_BIMM: begin
        dp.op_a = s.breg;
        dp.op_b = imm;
      end
      and_unit_pkg::V_LIMM: begin
        dp.op_a = s.lreg;
        dp.op_b = imm;
      end
      and_unit_pkg::V_HIMM: begin
        dp.op_a = s.hreg;
        dp.op_b = imm;
      end
      and_unit_pkg::V_SCIMM: begin
        dp.op_a = s.sc;
        dp.op_b = imm;
      end
      and_unit_pkg::V_MABS8IMM: begin
        dp.op_a = s.mem_data;
        dp.op_b = s.instr[23:16];
      end
      default: begin
        dp.op_a = s.acc;
        dp.op_b = s.mem_data;
      end
    endcase
  end

  // Register read view
  // Unmapped offsets read as zero.

  always_comb begin
    rd_word = 32'h0000_0000;
    unique case (avs_address)
      and_unit_pkg::REG_CTRL: begin
        rd_word[and_unit_pkg::CTRL_VAR_LSB +: 4] = s.var_sel;
        rd_word[and_unit_pkg::CTRL_IRSEL]        = s.ir_sel;
        rd_word[and_unit_pkg::CTRL_RSEL]         = s.r_sel;
        rd_word[and_unit_pkg::CTRL_PAGED]        = s.paged;
        rd_word[and_unit_pkg::CTRL_BUSY]         = (s.st == ST_RUN);
        rd_word[and_unit_pkg::CTRL_ACT_LSB +: 4] = s.act;
      end
      and_unit_pkg::REG_INSTR:   rd_word = s.instr;
      and_unit_pkg::REG_BA:      rd_word[15:0] = {s.breg, s.acc};
      and_unit_pkg::REG_HL:      rd_word[15:0] = {s.hreg, s.lreg};
      and_unit_pkg::REG_IX:      rd_word[15:0] = s.ix;
      and_unit_pkg::REG_IY:      rd_word[15:0] = s.iy;
      and_unit_pkg::REG_PAGES:   rd_word = {s.yp, s.xp, s.ep, s.br};
      and_unit_pkg::REG_SC:      rd_word[7:0] = s.sc;
      and_unit_pkg::REG_MEMADDR: rd_word[23:0] = s.mem_addr;
      default:                   rd_word = 32'h0000_0000;
    endcase
  end

  assign merged  = and_unit_pkg::merge_bytes(rd_word, avs_writedata,
                                             avs_byteenable);
  // Writes wait while an instruction runs, so registers stay stable
  assign wr_ok   = avs_write && (s.st == ST_IDLE);
  assign new_var = and_unit_pkg::variant_t'(
                     merged[and_unit_pkg::CTRL_VAR_LSB +: 4]);
  assign start_var = prefixed ? and_unit_pkg::V_HIMM : new_var;
  assign start   = wr_ok && (avs_address == and_unit_pkg::REG_CTRL) &&
                   avs_byteenable[0] &&
                   avs_writedata[and_unit_pkg::CTRL_START] &&
                   (prefixed || legal(new_var));

  always_comb begin
    next_s        = s;
    next_s.mem_rd = 1'b0;
    next_s.mem_wr = 1'b0;
    next_s.rd_ack = avs_read && !s.rd_ack;
    if (avs_read && !s.rd_ack) next_s.rdata = rd_word;

    if (wr_ok) begin
      unique case (avs_address)
        and_unit_pkg::REG_CTRL: begin
          next_s.var_sel = new_var;
          next_s.ir_sel  = merged[and_unit_pkg::CTRL_IRSEL];
          next_s.r_sel   = merged[and_unit_pkg::CTRL_RSEL];
          next_s.paged   = merged[and_unit_pkg::CTRL_PAGED];
        end
        and_unit_pkg::REG_INSTR: next_s.instr = merged;
        and_unit_pkg::REG_BA: begin
          next_s.acc  = merged[7:0];
          next_s.breg = merged[15:8];
        end
        and_unit_pkg::REG_HL: begin
          next_s.lreg = merged[7:0];
          next_s.hreg = merged[15:8];
        end
        and_unit_pkg::REG_IX: next_s.ix = merged[15:0];
        and_unit_pkg::REG_IY: next_s.iy = merged[15:0];
        and_unit_pkg::REG_PAGES: begin
          next_s.br = merged[7:0];
          next_s.ep = merged[15:8];
          next_s.xp = merged[23:16];
          next_s.yp = merged[31:24];
        end
        and_unit_pkg::REG_SC: next_s.sc = merged[7:0];
        default: begin
          next_s.sc = s.sc;
        end
      endcase
    end


    // Sequencer
    // Only one instruction at a time;
    // a new start waits for busy to fall.

    unique case (s.st)
      ST_IDLE: begin
        if (start) begin
          next_s.st    = ST_RUN;
          next_s.act   = start_var;
          next_s.cnt   = 5'h00;
          next_s.total = and_unit_pkg::clocks_of(start_var);
        end
      end
      ST_RUN: begin
        next_s.cnt = 5'(s.cnt + 5'h01);
        if (s.cnt == 5'h00) begin
          next_s.mem_addr = dp.addr;
          next_s.mem_rd   = reads_mem(s.act);
        end
        // Memory answers in the clock after the strobe
        if (s.cnt == and_unit_pkg::CNT_CAPTURE) begin
          next_s.mem_data = mem_rdata;
        end
        // Results land on the last clock, so the cycle count is exact
        if (s.cnt == 5'(s.total - 5'h01)) begin
          next_s.st = ST_IDLE;
          if (s.act != and_unit_pkg::V_SCIMM) begin
            next_s.sc[and_unit_pkg::SC_N] = dp.neg;
            next_s.sc[and_unit_pkg::SC_Z] = dp.zero;
          end
          unique case (s.act)
            and_unit_pkg::V_AR,
            and_unit_pkg::V_AIMM,
            and_unit_pkg::V_AABS8,
            and_unit_pkg::V_AABS16,
            and_unit_pkg::V_AHL,
            and_unit_pkg::V_AIR,
            and_unit_pkg::V_AIRDD,
            and_unit_pkg::V_AIRL: begin
              next_s.acc = dp.result;
            end
            and_unit_pkg::V_BIMM: next_s.breg = dp.result;
            and_unit_pkg::V_LIMM: next_s.lreg = dp.result;
            and_unit_pkg::V_HIMM: next_s.hreg = dp.result;
            and_unit_pkg::V_SCIMM: begin
              // Interrupt mask bits are replaced like the rest
              next_s.sc = dp.result;
            end
            and_unit_pkg::V_MABS8IMM: begin
              next_s.mem_wr    = 1'b1;
              next_s.mem_wdata = dp.result;
            end
            default: begin
              next_s.acc = s.acc;
            end
          endcase
        end
      end
    endcase
  end

  // Reset loads constants only, field by field

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s.st        <= ST_IDLE;
      s.var_sel   <= and_unit_pkg::V_AR;
      s.act       <= and_unit_pkg::V_AR;
      s.ir_sel    <= 1'b0;
      s.r_sel     <= 1'b0;
      s.paged     <= 1'b0;
      s.instr     <= 32'h0000_0000;
      s.acc       <= and_unit_pkg::RST_BYTE;
      s.breg      <= and_unit_pkg::RST_BYTE;
      s.lreg      <= and_unit_pkg::RST_BYTE;
      s.hreg      <= and_unit_pkg::RST_BYTE;
      s.ix        <= and_unit_pkg::RST_WORD;
      s.iy        <= and_unit_pkg::RST_WORD;
      s.br        <= and_unit_pkg::RST_BYTE;
      s.ep        <= and_unit_pkg::RST_BYTE;
      s.xp        <= and_unit_pkg::RST_BYTE;
      s.yp        <= and_unit_pkg::RST_BYTE;
      s.sc        <= and_unit_pkg::RST_SC;
      s.cnt       <= 5'h00;
      s.total     <= 5'h00;
      s.mem_data  <= 8'h00;
      s.mem_addr  <= 24'h00_0000;
      s.mem_rd    <= 1'b0;
      s.mem_wr    <= 1'b0;
      s.mem_wdata <= 8'h00;
      s.rd_ack    <= 1'b0;
      s.rdata     <= 32'h0000_0000;
    end else begin
      s <= next_s;
    end
  end


  // Bus and memory outputs
  // Reads take one wait state so that read data come from a register
  assign avs_waitrequest = (avs_write && (s.st == ST_RUN)) ||
                           (avs_read && !s.rd_ack);
  assign avs_readdata    = s.rdata;
  assign mem_addr        = s.mem_addr;
  assign mem_rd          = s.mem_rd;
  assign mem_wr          = s.mem_wr;
  assign mem_wdata       = s.mem_wdata;
  assign busy            = (s.st == ST_RUN);

endmodule

/* and_unit_pkg.sv */
// Constants, types and helpers for the logical AND instruction datapath.
// Assumes one 40 MHz clock and an Avalon-MM register slave.
// Behaviour
// - AND A with A or B register, result back into A.
// - AND immediate into A, two cycles.
// - 8-bit absolute: base page high, operand low byte; three cycles.
// - Paged models take data page for 8/16-bit absolute and pointer forms.
// - 16-bit absolute address from the instruction, AND into A.
// - AND byte at pointer pair into A, two cycles.
// - Index forms use first or second index page by selected index.
// - Index plus signed displacement -128..127, AND into A, four cycles.
// - Index plus signed low pointer byte, AND into A, four cycles.
// - AND immediate into B register, three cycles.
// - AND immediate into low pointer byte, three cycles.
// - Prefix CEH then B2 with immediate ANDs into high pointer byte.
// - AND immediate into whole system flag byte, all eight flags replaced.
// - AND immediate into base-page addressed memory, five cycles.
package and_unit_pkg;
  localparam logic [5:0]  REG_CTRL       = 6'h00;
  localparam logic [5:0]  REG_INSTR      = 6'h04;
  localparam logic [5:0]  REG_BA         = 6'h08;
  localparam logic [5:0]  REG_HL         = 6'h0C;
  localparam logic [5:0]  REG_IX         = 6'h10;
  localparam logic [5:0]  REG_IY         = 6'h14;
  localparam logic [5:0]  REG_PAGES      = 6'h18;
  localparam logic [5:0]  REG_SC         = 6'h1C;
  localparam logic [5:0]  REG_MEMADDR    = 6'h20;
  localparam int          CTRL_START     = 0;
  localparam int          CTRL_VAR_LSB   = 1;
  localparam int          CTRL_IRSEL     = 5;
  localparam int          CTRL_RSEL      = 6;
  localparam int          CTRL_PAGED     = 7;
  localparam int          CTRL_BUSY      = 8;
  localparam int          CTRL_ACT_LSB   = 9;
  localparam int          SC_N           = 3;
  localparam int          SC_Z           = 0;
  localparam logic [7:0]  RST_BYTE       = 8'h00;
  localparam logic [15:0] RST_WORD       = 16'h0000;
  localparam logic [7:0]  RST_SC         = 8'h00;
  localparam logic [7:0]  PREFIX_BYTE    = 8'hCE;
  localparam logic [7:0]  PREFIX_AND_H   = 8'hB2;
  localparam logic [4:0]  CLK_PER_CYCLE  = 5'h02;
  localparam logic [4:0]  CYC_TWO        = 5'h02;
  localparam logic [4:0]  CYC_THREE      = 5'h03;
  localparam logic [4:0]  CYC_FOUR       = 5'h04;
  localparam logic [4:0]  CYC_FIVE       = 5'h05;
  localparam logic [4:0]  CYC_ABS16      = 5'h04;
  localparam logic [4:0]  CYC_IR         = 5'h03;
  localparam logic [4:0]  CNT_CAPTURE    = 5'h02;

  typedef enum logic [3:0] {
    V_AR = 4'h0, V_AIMM = 4'h1, V_AABS8 = 4'h2, V_AABS16 = 4'h3,
    V_AHL = 4'h4, V_AIR = 4'h5, V_AIRDD = 4'h6, V_AIRL = 4'h7,
    V_BIMM = 4'h8, V_LIMM = 4'h9, V_HIMM = 4'hA, V_SCIMM = 4'hB,
    V_MABS8IMM = 4'hC
  } variant_t;

  typedef enum logic [2:0] {
    AM_NONE = 3'h0, AM_ABS8 = 3'h1, AM_ABS16 = 3'h2, AM_HL = 3'h3,
    AM_IR = 3'h4, AM_IRDD = 3'h5, AM_IRL = 3'h6
  } addr_mode_t;

  function automatic logic [4:0] clocks_of(input variant_t v);
    logic [4:0] c;
    c = CYC_THREE;
    unique case (v)
      V_AR, V_AIMM, V_AHL: c = CYC_TWO;
      V_AABS16:            c = CYC_ABS16;
      V_AIR:               c = CYC_IR;
      V_AIRDD, V_AIRL:     c = CYC_FOUR;
      V_MABS8IMM:          c = CYC_FIVE;
      default:             c = CYC_THREE;
    endcase
    return 5'(c * CLK_PER_CYCLE);
  endfunction

  function automatic addr_mode_t mode_of(input variant_t v);
    addr_mode_t m;
    m = AM_NONE;
    unique case (v)
      V_AABS8, V_MABS8IMM: m = AM_ABS8;
      V_AABS16:            m = AM_ABS16;
      V_AHL:               m = AM_HL;
      V_AIR:               m = AM_IR;
      V_AIRDD:             m = AM_IRDD;
      V_AIRL:              m = AM_IRL;
      default:             m = AM_NONE;
    endcase
    return m;
  endfunction

  function automatic logic [31:0] merge_bytes(input logic [31:0] old_w,
                                              input logic [31:0] new_w,
                                              input logic [3:0]  be);
    logic [31:0] r;
    r = old_w;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) r[i*8 +: 8] = new_w[i*8 +: 8];
    end
    return r;
  endfunction
endpackage

/* datapath_if.sv */
// Operand, result and address signals between the sequencer and its units.
// Assumes all producers are combinational within one clock.
`timescale 1ns/10ps
interface datapath_if;
  logic [7:0]              op_a;
  logic [7:0]              op_b;
  logic [7:0]              result;
  logic                    neg;
  logic                    zero;
  and_unit_pkg::addr_mode_t mode;
  logic                    paged;
  logic                    ir_sel;
  logic [7:0]              br;
  logic [7:0]              ep;
  logic [7:0]              xp;
  logic [7:0]              yp;
  logic [7:0]              ll;
  logic [7:0]              hh;
  logic [7:0]              l_off;
  logic [15:0]             hl;
  logic [15:0]             ix;
  logic [15:0]             iy;
  logic [23:0]             addr;
  modport alu (input op_a, op_b, output result, neg, zero);
  modport agu (input mode, paged, ir_sel, br, ep, xp, yp, ll, hh, l_off,
               hl, ix, iy, output addr);
  modport core (output op_a, op_b, mode, paged, ir_sel, br, ep, xp, yp,
                ll, hh, l_off, hl, ix, iy,
                input result, neg, zero, addr);
endinterface

/* and_logic_unit.sv */
// Bitwise AND with negative and zero result flags.
// Assumes operands are stable for the clock in which the result is used.
`timescale 1ns/10ps
module and_logic_unit (
  datapath_if.alu dp
);
  // No carry chain, so each bit depends only on its own pair
  assign dp.result = dp.op_a & dp.op_b;
  assign dp.neg    = dp.result[7];
  assign dp.zero   = (dp.result == 8'h00);
endmodule

/* address_unit.sv */
// Data memory address generation for every memory operand form.
// Assumes register values are held steady while an instruction runs.
`timescale 1ns/10ps
module address_unit (
  datapath_if.agu dp
);
  logic [7:0]  page;
  logic [15:0] base;
  logic [15:0] low;

  always_comb begin
    base = dp.ir_sel ? dp.iy : dp.ix;
    page = dp.ir_sel ? dp.yp : dp.xp;
    low  = 16'h0000;
    unique case (dp.mode)
      and_unit_pkg::AM_NONE:  low = 16'h0000;
      and_unit_pkg::AM_ABS8: begin
        page = dp.ep;
        low  = {dp.br, dp.ll};
      end
      and_unit_pkg::AM_ABS16: begin
        page = dp.ep;
        low  = {dp.hh, dp.ll};
      end
      and_unit_pkg::AM_HL: begin
        page = dp.ep;
        low  = dp.hl;
      end
      and_unit_pkg::AM_IR:   low = base;
      and_unit_pkg::AM_IRDD: low = base + {{8{dp.ll[7]}}, dp.ll};
      and_unit_pkg::AM_IRL:  low = base + {{8{dp.l_off[7]}},
                                           dp.l_off};
      default:  low = 16'h0000;
    endcase
    // Flat model: the page byte plays no part
    if (!dp.paged) page = 8'h00;
    dp.addr = {page, low};
  end
endmodule

/* data_mem_model.sv */
// Data memory partner: byte store, read data one clock after the strobe.
// Assumes single-clock read and write strobes from the AND unit.
`timescale 1ns/10ps
module data_mem_model (
  input  wire logic        clk,
  input  wire logic [23:0] mem_addr,
  input  wire logic        mem_rd,
  input  wire logic        mem_wr,
  input  wire logic [7:0]  mem_wdata,
  output logic [7:0]       mem_rdata
);
  logic [7:0] mem [logic [23:0]];
  initial mem_rdata = 8'h00;
  // Outside the answer clock the bus is scrambled so stale data is not reused
  always @(posedge clk) begin
    if (mem_rd && mem.exists(mem_addr)) mem_rdata <= mem[mem_addr];
    else mem_rdata <= ~mem_rdata;
    if (mem_wr) mem[mem_addr] = mem_wdata;
  end
endmodule

/* and_unit_asserts.sv */
// Checker for bus handshake, busy length and memory strobe timing.
// Assumes one clock domain; bound onto the unit's top module.
`timescale 1ns/10ps
module and_unit_checker (
  input wire logic        clk,
  input wire logic        arst_n,
  input wire logic [5:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic        avs_waitrequest,
  input wire logic [23:0] mem_addr,
  input wire logic        mem_rd,
  input wire logic        mem_wr,
  input wire logic        busy
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  sequence s_start;
    avs_write && !avs_waitrequest && !busy && avs_address == 6'h00
      && avs_writedata[0] && avs_writedata[4:1] <= 4'hC;
  endsequence
  sequence s_rd_first;
    avs_read && !$past(avs_read) ##1 avs_read;
  endsequence
  a_start_busy: assert property (s_start |=> busy)
    else $error("busy missing after start");
  a_busy_len: assert property ($rose(busy) |->
    busy [*4] ##[1:7] !busy)
    else $error("busy length out of range");
  a_rd_second_clock: assert property (mem_rd |->
    busy && $past(busy) && !$past(busy, 2))
    else $error("read strobe not in second busy clock");
  a_rd_pulse: assert property (mem_rd |=> !mem_rd)
    else $error("read strobe too long");
  a_wr_after_busy: assert property (mem_wr |->
    $fell(busy) && $stable(mem_addr) ##1 !mem_wr)
    else $error("write strobe misplaced");
  a_addr_hold: assert property (mem_rd |=> $stable(mem_addr) [*2])
    else $error("address moved during read");
  a_write_stall: assert property (avs_write && busy |-> avs_waitrequest)
    else $error("write accepted while busy");
  a_write_idle: assert property (avs_write && !busy |-> !avs_waitrequest)
    else $error("idle write stalled");
  a_read_wait: assert property (avs_read && !$past(avs_read)
    |-> avs_waitrequest)
    else $error("read answered in first clock");
  a_read_ack: assert property (s_rd_first |-> !avs_waitrequest)
    else $error("read not answered in second clock");
endmodule
bind logical_and_instruction_unit and_unit_checker and_unit_checker_inst (
  .clk(clk), .arst_n(arst_n), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_waitrequest(avs_waitrequest),
  .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_wr(mem_wr), .busy(busy));

/* tb_logical_and_instruction_unit.sv */
// Self-checking bench for the AND unit, driven over its register bus.
// Assumes the data memory model answers one clock after each read strobe.
`timescale 1ns/10ps
module tb_logical_and_instruction_unit;
  logic        clk = 1'b0;
  logic        arst_n = 1'b0;
  logic [5:0]  avs_address = 6'h00;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h00000000;
  logic [3:0]  avs_byteenable = 4'hF;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest, mem_rd, mem_wr, busy;
  logic [23:0] mem_addr, rd_addr, wr_addr;
  logic [7:0]  mem_wdata, mem_rdata, wr_data;
  int          num_errors = 0, n_tests = 0, cyc = 0, bclk = 0, rd_cnt = 0;

  logical_and_instruction_unit logical_and_instruction_unit_inst (
    .clk(clk), .arst_n(arst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_wr(mem_wr),
    .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .busy(busy));
  data_mem_model data_mem_model_inst (
    .clk(clk), .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_wr(mem_wr),
    .mem_wdata(mem_wdata), .mem_rdata(mem_rdata));

  always #12.5 clk = ~clk;
  // Sampled mid-cycle so registered outputs have settled
  always @(negedge clk) begin
    if (busy === 1'b1) bclk++;
    if (mem_rd === 1'b1) begin
      rd_cnt++;
      rd_addr = mem_addr;
    end
    if (mem_wr === 1'b1) begin
      wr_addr = mem_addr;
      wr_data = mem_wdata;
    end
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 6000) begin
      num_errors++;
      results();
    end
  end

  task automatic results();
    $display("checks %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic check(input string nm, input logic [31:0] seen, exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Waitrequest and read data are taken at the falling edge before each rising edge
  task automatic ack(output logic [31:0] d);
    logic w;
    do begin
      @(negedge clk);
      w = avs_waitrequest;
      d = avs_readdata;
      @(posedge clk);
    end while (w !== 1'b0);
  endtask
  task automatic wr(input logic [5:0] a, input logic [31:0] v,
                    input logic [3:0] be = 4'hF);
    logic [31:0] d;
    avs_address <= a;
    avs_writedata <= v;
    avs_byteenable <= be;
    avs_write <= 1'b1;
    ack(d);
    avs_write <= 1'b0;
    @(posedge clk);
  endtask
  task automatic chk_rd(input string nm, input logic [5:0] a,
                        input logic [31:0] e);
    logic [31:0] d;
    avs_address <= a;
    avs_read <= 1'b1;
    ack(d);
    avs_read <= 1'b0;
    @(posedge clk);
    check(nm, d, e);
  endtask
  // cw bits 7..1: paged, r select, index select, variant; start added here
  task automatic op(input logic [7:0] cw, input logic [23:0] ins,
      input logic [15:0] ba, hl, input logic [7:0] sc,
      input logic [15:0] eba, ehl, input logic [7:0] esc, input int cy,
      input logic [23:0] ea = 24'hFFFFFF);
    logic [3:0] av;
    av = (ins[15:0] == 16'hB2CE) ? 4'hA : cw[4:1];
    wr(6'h08, {16'h0000, ba});
    wr(6'h0C, {16'h0000, hl});
    wr(6'h1C, {24'h000000, sc});
    wr(6'h04, {8'h00, ins});
    bclk = 0;
    rd_cnt = 0;
    wr(6'h00, {24'h000000, cw | 8'h01});
    chk_rd("ctrl", 6'h00, {19'h00000, av, 1'b1, cw[7:1], 1'b0});
    do @(negedge clk); while (busy !== 1'b0);
    @(posedge clk);
    check("clocks", bclk, cy * 2);
    chk_rd("ba", 6'h08, {16'h0000, eba});
    chk_rd("hl", 6'h0C, {16'h0000, ehl});
    chk_rd("sc", 6'h1C, {24'h000000, esc});
    check("reads", rd_cnt, (ea === 24'hFFFFFF) ? 0 : 1);
    if (ea !== 24'hFFFFFF) check("addr", {8'h00, rd_addr}, {8'h00, ea});
  endtask

  task automatic t_reset();
    for (int i = 0; i < 10; i++) chk_rd("reset", 6'(i * 4), 32'h00000000);
    $display("test reset done");
  endtask
  task automatic t_regs();
    op(8'h40, 24'h000000, 16'h613B, 16'h0000, 8'hFF, 16'h6121, 16'h0000,
       8'hF6, 2);
    op(8'h00, 24'h000000, 16'h00D6, 16'h0000, 8'h00, 16'h00D6, 16'h0000,
       8'h08, 2);
    op(8'h02, 24'h00A500, 16'h005A, 16'h0000, 8'h00, 16'h0000, 16'h0000,
       8'h01, 2);
    op(8'h10, 24'h009300, 16'hD611, 16'h0000, 8'h76, 16'h9211, 16'h0000,
       8'h7E, 3);
    op(8'h12, 24'h006100, 16'h0000, 16'h553B, 8'h01, 16'h0000, 16'h5521,
       8'h00, 3);
    op(8'h00, 24'h93B2CE, 16'h0000, 16'hD677, 8'h00, 16'h0000, 16'h9277,
       8'h08, 3);
    op(8'h16, 24'h009300, 16'h0000, 16'h0000, 8'hD6, 16'h0000, 16'h0000,
       8'h92, 3);
    op(8'h16, 24'h006100, 16'h0000, 16'h0000, 8'h3B, 16'h0000, 16'h0000,
       8'h21, 3);
    $display("test register forms done");
  endtask
  task automatic t_mem();
    logic [23:0] ma [8] = '{24'h00115A, 24'h22115A, 24'h221234, 24'h225678,
                           24'h330F80, 24'h4420FF, 24'h330FFF, 24'h442080};
    logic [7:0]  mv [8] = '{8'h61, 8'h93, 8'hA5, 8'h61,
                           8'h93, 8'hA5, 8'h61, 8'h93};
    for (int i = 0; i < 8; i++) data_mem_model_inst.mem[ma[i]] = mv[i];
    wr(6'h18, 32'h44332211);
    wr(6'h10, 32'h00001000);
    wr(6'h14, 32'h00002080);
    op(8'h04, 24'h005A00, 16'h003B, 16'h0000, 8'h00, 16'h0021, 16'h0000,
       8'h00, 3, 24'h00115A);
    op(8'h84, 24'h005A00, 16'h00D6, 16'h0000, 8'h00, 16'h0092, 16'h0000,
       8'h08, 3, 24'h22115A);
    op(8'h86, 24'h123400, 16'h005A, 16'h0000, 8'h00, 16'h0000, 16'h0000,
       8'h01, 4, 24'h221234);
    op(8'h88, 24'h000000, 16'h003B, 16'h5678, 8'h00, 16'h0021, 16'h5678,
       8'h00, 2, 24'h225678);
    op(8'h8C, 24'h008000, 16'h00D6, 16'h0000, 8'h00, 16'h0092, 16'h0000,
       8'h08, 4, 24'h330F80);
    op(8'hAC, 24'h007F00, 16'h005A, 16'h0000, 8'h00, 16'h0000, 16'h0000,
       8'h01, 4, 24'h4420FF);
    op(8'h8E, 24'h000000, 16'h003B, 16'h00FF, 8'h00, 16'h0021, 16'h00FF,
       8'h00, 4, 24'h330FFF);
    op(8'hAA, 24'h000000, 16'h00D6, 16'h0000, 8'h00, 16'h0092, 16'h0000,
       8'h08, 3, 24'h442080);
    op(8'h98, 24'hA55A00, 16'h0077, 16'h0000, 8'h00, 16'h0077, 16'h0000,
       8'h08, 5, 24'h22115A);
    check("wr addr", {8'h00, wr_addr}, 32'h0022115A);
    check("wr data", {24'h000000, wr_data}, 32'h00000081);
    $display("test memory forms done");
  endtask
  task automatic t_refuse();
    wr(6'h3C, 32'hFFFFFFFF);
    chk_rd("unmapped", 6'h3C, 32'h00000000);
    wr(6'h08, 32'h0000ABCD);
    wr(6'h08, 32'h00001200, 4'h2);
    chk_rd("lane", 6'h08, 32'h000012CD);
    bclk = 0;
    wr(6'h04, 32'h00000000);
    wr(6'h00, 32'h0000001B);
    repeat (4) @(posedge clk);
    check("illegal", bclk, 0);
    // A write issued during the run must wait and land after the result
    wr(6'h08, 32'h000000F0);
    wr(6'h04, 32'h00000F00);
    wr(6'h00, 32'h00000003);
    wr(6'h08, 32'h000000FF);
    check("stall", bclk, 4);
    chk_rd("late", 6'h08, 32'h000000FF);
    $display("test refusals done");
  endtask

  initial begin
    repeat (12) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    t_reset();
    t_regs();
    t_mem();
    t_refuse();
    results();
  end
endmodule
